/* hdl/spcg_pkg.sv */
/*
 * Constants for the sleep-mode port clock gating block.
 * Assumes a 32-bit system address map with the control block at one base.
 */
package spcg_pkg;
	localparam int SPCG_PORTS = 8;
	localparam int SPCG_DATA_W = 32;
	localparam logic [31:0] SPCG_CTRL_BASE = 32'h400fe000;
	localparam logic [31:0] SPCG_SLEEP_GATE_OFF = 32'h00000118;
	localparam logic [31:0] SPCG_EFFECTIVE_OFF = 32'h0000011c;
	localparam logic [7:0] SPCG_SLEEP_GATE_RESET = 8'h00;
	localparam logic [7:0] SPCG_CLOCK_ON_RESET = 8'h00;
	localparam int SPCG_GATE_LSB = 0;
	localparam int SPCG_GATE_MSB = 7;
	localparam logic [31:0] SPCG_READ_ZERO = 32'h00000000;
endpackage

/* hdl/spcg_gate_if.sv */
/*
 * Carrier between the register top and the gate selector.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface spcg_gate_if;
	import spcg_pkg::*;
	logic [SPCG_PORTS-1:0] sleepGates;
	logic [SPCG_PORTS-1:0] runGates;
	logic [SPCG_PORTS-1:0] clockOn;
	logic [SPCG_PORTS-1:0] portAccess;
	logic sleepMode;
	logic autoGate;
	logic [SPCG_PORTS-1:0] clockOnNext;
	logic faultNext;
	modport top (output sleepGates, runGates, clockOn, portAccess,
		sleepMode, autoGate, input clockOnNext, faultNext);
	modport sel (input sleepGates, runGates, clockOn, portAccess,
		sleepMode, autoGate, output clockOnNext, faultNext);
endinterface
`default_nettype wire

/* hdl/spcg_gate_select.sv */
/*
 * Chooses each port's next clock enable and detects accesses to gated ports.
 * Assumes the top registers the results so enables change only on clk.
 */
`timescale 1ns/1ps
`default_nettype none
module spcg_gate_select
	import spcg_pkg::*;
(
	spcg_gate_if.sel gi
);
	// ----------------------------------------
	// Enable selection and fault detect
	// ----------------------------------------
	always_comb begin
		if (gi.sleepMode && gi.autoGate) begin
			gi.clockOnNext = gi.sleepGates;
		end else begin
			gi.clockOnNext = gi.runGates;
		end
		gi.faultNext = |(gi.portAccess & ~gi.clockOn);
	end
endmodule
`default_nettype wire

/* hdl/spcg_sleep_gate.sv */
/*
 * Sleep-mode port clock gating register and per-port enable outputs.
 * Assumes mode, run-mode gates, auto-gate select and port access strobes
 * come from logic on clk; enables feed glitch-free clock gates.
 */
// Our own choice: the strobed register port.
// Summary of operation
// - Bits 7..0 enable ports H..A; set clocks port, clear gates it.
// - Access to a port whose clock is gated returns a bus fault.
// - Reset clears all gating bits; every port starts unclocked.
// - Register bits 31..8 are read-only and read as zero.
// - This register steers port clocks only while in Sleep.
// - Sleep gating applies only when auto gating select is set.
// - Register decodes at offset 0x118 from base 0x400fe000.
`timescale 1ns/1ps
`default_nettype none
module spcg_sleep_gate
	import spcg_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Register port
	input wire logic [31:0] regAddr,
	input wire logic [31:0] regWdata,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [31:0] regRdata,
	// Mode and run-mode gates
	input wire logic sleepMode,
	input wire logic autoSleepGatingSelect,
	input wire logic [SPCG_PORTS-1:0] runPortClockGates,
	// Port access and results
	input wire logic [SPCG_PORTS-1:0] portAccess,
	output logic [SPCG_PORTS-1:0] portClockOn,
	output logic busFault
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [SPCG_PORTS-1:0] sleepGates;
		logic [SPCG_PORTS-1:0] clockOn;
		logic fault;
		logic [31:0] rdata;
	} spcg_state_t;

	spcg_state_t state_reg;
	spcg_state_t state_next;
	logic hitSleep;
	logic hitEffective;

	spcg_gate_if gi();

	assign gi.sleepGates = state_reg.sleepGates;
	assign gi.runGates = runPortClockGates;
	assign gi.clockOn = state_reg.clockOn;
	assign gi.portAccess = portAccess;
	assign gi.sleepMode = sleepMode;
	assign gi.autoGate = autoSleepGatingSelect;

	spcg_gate_select u_select (
		.gi(gi)
	);

	// ----------------------------------------
	// Address decode
	// ----------------------------------------
	function automatic logic regHit(input logic [31:0] addr,
		input logic [31:0] off);
		return addr == SPCG_CTRL_BASE + off;
	endfunction

	assign hitSleep = regHit(regAddr, SPCG_SLEEP_GATE_OFF);
	assign hitEffective = regHit(regAddr, SPCG_EFFECTIVE_OFF);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		state_next = state_reg;
		if (regWrite && hitSleep) begin
			state_next.sleepGates =
				regWdata[SPCG_GATE_MSB:SPCG_GATE_LSB];
		end
		state_next.clockOn = gi.clockOnNext;
		state_next.fault = gi.faultNext;
		state_next.rdata = SPCG_READ_ZERO;
		if (regRead && hitSleep) begin
			state_next.rdata[SPCG_GATE_MSB:SPCG_GATE_LSB] =
				state_reg.sleepGates;
		end else if (regRead && hitEffective) begin
			state_next.rdata[SPCG_GATE_MSB:SPCG_GATE_LSB] =
				state_reg.clockOn;
		end
		if (!resetn) begin
			state_next.sleepGates = SPCG_SLEEP_GATE_RESET;
			state_next.clockOn = SPCG_CLOCK_ON_RESET;
			state_next.fault = 1'b0;
			state_next.rdata = SPCG_READ_ZERO;
		end
	end

	always_ff @(posedge clk) begin
		state_reg <= state_next;
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign regRdata = state_reg.rdata;
	assign portClockOn = state_reg.clockOn;
	assign busFault = state_reg.fault;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_reset_clear: assert property (@(posedge clk)
		!resetn |=> (state_reg.sleepGates == 8'h00 && portClockOn == 8'h00))
		else $error("gates not cleared by reset");
	chk_write_gates: assert property (@(posedge clk)
		disable iff (!resetn)
		regWrite && hitSleep
		|=> state_reg.sleepGates == $past(regWdata[7:0]))
		else $error("gate write not stored");
	chk_upper_zero: assert property (@(posedge clk)
		disable iff (!resetn)
		regRead && hitSleep |=> regRdata[31:8] == 24'h000000)
		else $error("reserved bits not zero");
	chk_decode_read: assert property (@(posedge clk)
		disable iff (!resetn)
		regRead && regAddr == 32'h400fe118
		|=> regRdata[7:0] == $past(state_reg.sleepGates))
		else $error("sleep gate register read wrong");
	chk_gated_fault: assert property (@(posedge clk)
		disable iff (!resetn)
		|(portAccess & ~portClockOn) |=> busFault)
		else $error("gated access without fault");
	chk_no_false_fault: assert property (@(posedge clk)
		disable iff (!resetn)
		busFault |-> $past(|(portAccess & ~portClockOn)))
		else $error("fault without gated access");
	chk_sleep_apply: assert property (@(posedge clk)
		disable iff (!resetn)
		sleepMode && autoSleepGatingSelect
		|=> portClockOn == $past(state_reg.sleepGates))
		else $error("sleep gates not applied");
	chk_auto_off: assert property (@(posedge clk)
		disable iff (!resetn)
		sleepMode && !autoSleepGatingSelect
		|=> portClockOn == $past(runPortClockGates))
		else $error("sleep gates used without auto select");
	chk_wake_run: assert property (@(posedge clk)
		disable iff (!resetn)
		$fell(sleepMode) |=> portClockOn == $past(runPortClockGates))
		else $error("run gates not restored on wake");

	// ----------------------------------------
	// Register and mode checks
	// ----------------------------------------
	chk_run_mode: assert property (@(posedge clk)
		disable iff (!resetn)
		!sleepMode |=> portClockOn == $past(runPortClockGates))
		else $error("run gates not used outside sleep");
	chk_fault_clear: assert property (@(posedge clk)
		disable iff (!resetn)
		!(|(portAccess & ~portClockOn)) |=> !busFault)
		else $error("fault raised on enabled access");
	chk_reset_outputs: assert property (@(posedge clk)
		!resetn |=> (!busFault && regRdata == SPCG_READ_ZERO))
		else $error("outputs not cleared by reset");
	chk_gates_hold: assert property (@(posedge clk)
		disable iff (!resetn)
		!regWrite |=> $stable(state_reg.sleepGates))
		else $error("gates changed without write");
	chk_write_other: assert property (@(posedge clk)
		disable iff (!resetn)
		regWrite && !hitSleep
		|=> state_reg.sleepGates == $past(state_reg.sleepGates))
		else $error("write to other address changed gates");
	chk_unmapped_read: assert property (@(posedge clk)
		disable iff (!resetn)
		regRead && !hitSleep && !hitEffective
		|=> regRdata == SPCG_READ_ZERO)
		else $error("unmapped read not zero");
	chk_effective_read: assert property (@(posedge clk)
		disable iff (!resetn)
		regRead && hitEffective
		|=> regRdata[7:0] == $past(portClockOn))
		else $error("effective enables read wrong");
	chk_effective_upper: assert property (@(posedge clk)
		disable iff (!resetn)
		regRead && hitEffective |=> regRdata[31:8] == 24'h000000)
		else $error("effective reserved bits not zero");
	chk_write_readback: assert property (@(posedge clk)
		disable iff (!resetn)
		(regWrite && hitSleep) ##1 (regRead && hitSleep)
		|=> regRdata[7:0] == $past(regWdata[7:0], 2))
		else $error("written gates not read back");
	chk_read_idle: assert property (@(posedge clk)
		disable iff (!resetn)
		!regRead |=> regRdata == SPCG_READ_ZERO)
		else $error("read data not zero between reads");
	chk_decode_write: assert property (@(posedge clk)
		disable iff (!resetn)
		regWrite && regAddr == 32'h400fe118
		|=> state_reg.sleepGates == $past(regWdata[7:0]))
		else $error("write at gate address not stored");

	// ----------------------------------------
	// Per-port checks
	// ----------------------------------------
	generate
		for (genvar p = 0; p < SPCG_PORTS; p++) begin : g_port
			chk_port_fault: assert property (@(posedge clk)
				disable iff (!resetn)
				portAccess[p] && !portClockOn[p] |=> busFault)
				else $error("gated port access without fault");
			chk_port_sleep: assert property (@(posedge clk)
				disable iff (!resetn)
				sleepMode && autoSleepGatingSelect
				|=> portClockOn[p] == $past(state_reg.sleepGates[p]))
				else $error("port enable ignores sleep gate");
			chk_port_run: assert property (@(posedge clk)
				disable iff (!resetn)
				!(sleepMode && autoSleepGatingSelect)
				|=> portClockOn[p] == $past(runPortClockGates[p]))
				else $error("port enable ignores run gate");
			chk_port_reset: assert property (@(posedge clk)
				!resetn |=> !portClockOn[p])
				else $error("port clock on after reset");
			chk_port_write: assert property (@(posedge clk)
				disable iff (!resetn)
				regWrite && hitSleep
				|=> state_reg.sleepGates[p] == $past(regWdata[p]))
				else $error("port gate bit not stored");
		end
	endgenerate
endmodule
`default_nettype wire

/* sim/spcg_port_model.sv */
/* Port-side model: turns a request vector into port access strobes.
   Assumes requests change just after a rising clk edge. */
`timescale 1ns/1ps
`default_nettype none
module spcg_port_model (
	// Clock
	input wire logic clk,
	// Requests and strobes
	input wire logic [7:0] req,
	output logic [7:0] portAccess
);
	// ----------------
	// Access strobe
	// ----------------
	always_ff @(posedge clk) begin
		portAccess <= req;
	end
endmodule
`default_nettype wire

/* sim/sleep_port_clock_gating_tb.sv */
/* Testbench for the sleep-mode port clock gating block.
   Assumes the design package and the port model are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module sleep_port_clock_gating_tb
	import spcg_pkg::*;
;
	logic clk = 1'b0, resetn = 1'b0, regWrite = 1'b0, regRead = 1'b0;
	logic sleepMode = 1'b0, autoSel = 1'b0, busFault;
	logic [31:0] regAddr = 32'h0, regWdata = 32'h0, regRdata;
	logic [7:0] runGates = 8'h00, req = 8'h00, portAccess, portClockOn;
	int errCount = 0, nCompared = 0;
	logic [31:0] rdVal = 32'h0;
	localparam logic [31:0] GATE_A = SPCG_CTRL_BASE + SPCG_SLEEP_GATE_OFF;
	always #20 clk = ~clk;
	spcg_port_model pm (.clk(clk), .req(req), .portAccess(portAccess));
	spcg_sleep_gate dut (.clk(clk), .resetn(resetn), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
		.regRdata(regRdata), .sleepMode(sleepMode),
		.autoSleepGatingSelect(autoSel), .runPortClockGates(runGates),
		.portAccess(portAccess), .portClockOn(portClockOn),
		.busFault(busFault));
	// ----------------
	// Tasks
	// ----------------
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		nCompared++;
		if (got !== exp) begin
			errCount++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		@(posedge clk) begin
			regWrite <= 1'b1;
			regAddr <= a;
			regWdata <= d;
		end
		@(posedge clk) regWrite <= 1'b0;
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] exp);
		@(posedge clk) begin
			regRead <= 1'b1;
			regAddr <= a;
		end
		@(posedge clk) regRead <= 1'b0;
		#1 cmp(regRdata, exp);
		rdVal = regRdata;
	endtask
	task automatic en(input logic [7:0] exp);
		repeat (2) @(posedge clk);
		#1 cmp({24'h0, portClockOn}, {24'h0, exp});
	endtask
	task automatic acc(input logic [7:0] v, input logic exp);
		@(posedge clk) req <= v;
		@(posedge clk) req <= 8'h00;
		@(posedge clk);
		#1 cmp({31'h0, busFault}, {31'h0, exp});
	endtask
	task automatic wrap_up;
		$display("errors %0d compares %0d", errCount, nCompared);
		if (errCount == 0 && nCompared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// ----------------
	// Tests
	// ----------------
	initial begin
		repeat (12) @(posedge clk);
		resetn <= 1'b1;
		#1 cmp({24'h0, portClockOn}, 32'h0);
		rd(GATE_A, 32'h0);
		wr(GATE_A, 32'hffffff05);
		rd(GATE_A, 32'h00000005);
		rd(GATE_A - 32'h10, 32'h0);
		wr(SPCG_SLEEP_GATE_OFF, 32'h000000ff);
		rd(GATE_A, 32'h00000005);
		wr(GATE_A, rdVal | 32'h00000008);
		rd(GATE_A, 32'h0000000d);
		@(posedge clk) begin
			sleepMode <= 1'b1;
			autoSel <= 1'b1;
			runGates <= 8'ha0;
		end
		en(8'h0d);
		acc(8'h02, 1'b1);
		acc(8'h01, 1'b0);
		wr(GATE_A, rdVal | 32'h00000002);
		acc(8'h02, 1'b0);
		rd(SPCG_CTRL_BASE + SPCG_EFFECTIVE_OFF, 32'h0000000f);
		@(posedge clk) autoSel <= 1'b0;
		en(8'ha0);
		@(posedge clk) autoSel <= 1'b1;
		en(8'h0f);
		@(posedge clk) sleepMode <= 1'b0;
		en(8'ha0);
		@(posedge clk) resetn <= 1'b0;
		repeat (2) @(posedge clk);
		resetn <= 1'b1;
		#1 cmp({24'h0, portClockOn}, 32'h0);
		rd(GATE_A, 32'h0);
		wrap_up;
	end
	initial begin
		repeat (2000) @(posedge clk);
		errCount++;
		wrap_up;
	end
endmodule
`default_nettype wire
